//--- sram_pins_map.vh
// constants for the pipelined burst sram pin interface
// assumes plain verilog-2005 consumers that include it by bare name
`ifndef SRAM_PINS_MAP_VH
`define SRAM_PINS_MAP_VH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define ADDR_W 18
`define DATA_W 16
`define PAR_W 2
`define LANES 2
`define LANE_W 8
`define DEPTH 262144
`define BURST_W 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_ADDR 18'h00000
`define RST_CNT 2'h0
`define RST_BW_N 2'h3
`define RST_DATA 16'h0000
`define RST_PAR 2'h0
`define RST_MODE 1'h1

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SLEEP_CYC 2
`define SLEEP_CNT_W 2

`endif

//--- burst_order.v
// burst address generator: low address bits for one burst step
// assumes the caller holds the loaded base and the step count
`timescale 1ns/1ns
`include "sram_pins_map.vh"

module burst_order
(
  input wire [`BURST_W-1:0] base_lo,
  input wire [`BURST_W-1:0] step,
  input wire linear,
  output wire [`BURST_W-1:0] addr_lo
);

  // ----------------------------------------------------------------
  // ordering
  // ----------------------------------------------------------------
  // linear adds and wraps in two bits, interleaved flips bits
  wire [`BURST_W-1:0] lin_lo;
  wire [`BURST_W-1:0] int_lo;

  assign lin_lo = base_lo + step; // wraps on purpose
  assign int_lo = base_lo ^ step;
  assign addr_lo = linear ? lin_lo : int_lo;

endmodule

//--- sram_pin_core.v
// device side of a pipelined burst sram: pin decode, pipeline, array
// assumes the controller drives all synchronous pins on core_clk;
// out_en_n, sleep_req and burst_mode_pin are asynchronous to it
`timescale 1ns/1ns
`include "sram_pins_map.vh"

module sram_pin_core
(
  input wire core_clk,
  input wire resetn,
  input wire [`ADDR_W-1:0] addr,
  input wire chip_sel_a_n,
  input wire chip_sel_b,
  input wire chip_sel_c_n,
  input wire write_n,
  input wire advance_or_load,
  input wire [`LANES-1:0] byte_write_sel_n,
  input wire clock_qualify_n,
  input wire out_en_n,
  input wire sleep_req,
  input wire burst_mode_pin,
  input wire [`DATA_W-1:0] dq_in,
  output wire [`DATA_W-1:0] dq_out,
  output wire dq_oe,
  input wire [`PAR_W-1:0] parity_bus_in,
  output wire [`PAR_W-1:0] parity_bus_out,
  output wire parity_bus_oe,
  output wire sleep_active
);

  // ----------------------------------------------------------------
  // asynchronous pin synchronisers
  // ----------------------------------------------------------------
  // out_en_n, sleep_req and the strap come from outside the clock
  reg oe_meta_r;
  reg oe_sync_r;
  reg zz_meta_r;
  reg zz_sync_r;
  reg mode_meta_r;
  reg mode_sync_r;

  // two flops each; the first is read only by the second
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      oe_meta_r <= 1'b1;
      oe_sync_r <= 1'b1;
      zz_meta_r <= 1'b0;
      zz_sync_r <= 1'b0;
    end
    else
    begin
      oe_meta_r <= out_en_n;
      oe_sync_r <= oe_meta_r;
      zz_meta_r <= sleep_req;
      zz_sync_r <= zz_meta_r;
    end
  end

  // strap flops run through reset, so the level caught after release
  // is the pin's own and not a reset constant
  always @(posedge core_clk)
  begin
    mode_meta_r <= burst_mode_pin;
    mode_sync_r <= mode_meta_r;
  end

  // ----------------------------------------------------------------
  // burst order strap
  // ----------------------------------------------------------------
  // strap caught once after release, so a moving pin cannot upset a burst
  reg strap_taken_r;
  reg interleave_r;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_taken_r <= 1'b0;
      interleave_r <= `RST_MODE;
    end
    else if (!strap_taken_r)
    begin
      strap_taken_r <= 1'b1;
      interleave_r <= mode_sync_r;
    end
  end

  // ----------------------------------------------------------------
  // sleep control
  // ----------------------------------------------------------------
  // entry and exit each take a fixed count of synced cycles
  reg asleep_r;
  reg [`SLEEP_CNT_W-1:0] zz_cnt_r;
  reg [`SLEEP_CNT_W-1:0] zz_cnt_nxt;
  reg asleep_nxt;

  always @*
  begin
    zz_cnt_nxt = zz_cnt_r;
    asleep_nxt = asleep_r;
    if (zz_sync_r == asleep_r)
    begin
      zz_cnt_nxt = {`SLEEP_CNT_W{1'b0}};
    end
    else if (zz_cnt_r == `SLEEP_CYC - 1)
    begin
      zz_cnt_nxt = {`SLEEP_CNT_W{1'b0}};
      asleep_nxt = zz_sync_r;
    end
    else
    begin
      zz_cnt_nxt = zz_cnt_r + 1'b1;
    end
  end

  // sleep runs on the raw clock: the qualifier does not gate it
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      asleep_r <= 1'b0;
      zz_cnt_r <= {`SLEEP_CNT_W{1'b0}};
    end
    else
    begin
      asleep_r <= asleep_nxt;
      zz_cnt_r <= zz_cnt_nxt;
    end
  end

  assign sleep_active = asleep_r;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire qual;
  wire sel_now;
  wire load_now;

  assign qual = ~clock_qualify_n;
  // all three selects must agree on the same edge
  assign sel_now = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n & ~asleep_r;
  assign load_now = ~advance_or_load;

  // ----------------------------------------------------------------
  // address and burst counter
  // ----------------------------------------------------------------
  reg [`ADDR_W-1:0] base_r;
  reg [`BURST_W-1:0] cnt_r;
  reg s1_valid_r;
  reg s1_wr_r;
  reg [`LANES-1:0] s1_bw_n_r;
  reg emerge_r;
  reg [`ADDR_W-1:0] base_nxt;
  reg [`BURST_W-1:0] cnt_nxt;
  reg s1_valid_nxt;
  reg s1_wr_nxt;
  wire [`BURST_W-1:0] addr_lo;
  wire [`ADDR_W-1:0] s1_addr;

  burst_order u_order
  (
    .base_lo(base_r[`BURST_W-1:0]),
    .step(cnt_r),
    .linear(~interleave_r),
    .addr_lo(addr_lo)
  );

  assign s1_addr = {base_r[`ADDR_W-1:`BURST_W], addr_lo};

  // load takes a fresh op; advance keeps op type and steps the count
  always @*
  begin
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    s1_valid_nxt = s1_valid_r;
    s1_wr_nxt = s1_wr_r;
    if (load_now)
    begin
      base_nxt = addr;
      cnt_nxt = `RST_CNT;
      s1_valid_nxt = sel_now;
      s1_wr_nxt = sel_now & ~write_n;
    end
    else
    begin
      cnt_nxt = cnt_r + 1'b1;
      s1_valid_nxt = s1_valid_r & ~asleep_r;
    end
  end

  // qualifier high holds every field; it never clears the select
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      base_r <= `RST_ADDR;
      cnt_r <= `RST_CNT;
      s1_valid_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_bw_n_r <= `RST_BW_N;
      emerge_r <= 1'b0;
    end
    else if (qual)
    begin
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      s1_valid_r <= s1_valid_nxt;
      s1_wr_r <= s1_wr_nxt;
      s1_bw_n_r <= byte_write_sel_n;
      emerge_r <= ~s1_valid_r & s1_valid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output and write stages
  // ----------------------------------------------------------------
  reg rd_valid_r;
  reg w2_valid_r;
  reg [`ADDR_W-1:0] w2_addr_r;
  reg [`LANES-1:0] w2_bw_n_r;

  // reads leave the array one qualified edge after the address edge
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_valid_r <= 1'b0;
      w2_valid_r <= 1'b0;
      w2_addr_r <= `RST_ADDR;
      w2_bw_n_r <= `RST_BW_N;
    end
    else if (asleep_r)
    begin
      // pending accesses are dropped on sleep entry
      rd_valid_r <= 1'b0;
      w2_valid_r <= 1'b0;
    end
    else if (qual)
    begin
      rd_valid_r <= s1_valid_r & ~s1_wr_r;
      w2_valid_r <= s1_valid_r & s1_wr_r;
      w2_addr_r <= s1_addr;
      w2_bw_n_r <= s1_bw_n_r;
    end
  end

  // ----------------------------------------------------------------
  // storage lanes
  // ----------------------------------------------------------------
  // one array per byte lane, parity bit on top of each byte
  wire [`DATA_W-1:0] rd_data;
  wire [`PAR_W-1:0] rd_par;
  wire wr_fire;
  wire rd_fire;

  assign wr_fire = qual & w2_valid_r & ~asleep_r;
  assign rd_fire = qual & s1_valid_r & ~s1_wr_r & ~asleep_r;

  genvar g;
  generate
    for (g = 0; g < `LANES; g = g + 1)
    begin : lane
      reg [`LANE_W:0] mem [0:`DEPTH-1];
      reg [`LANE_W:0] lane_q_r;
      wire hit;

      // write data phase landing on the word a read is starting on
      assign hit = wr_fire & ~w2_bw_n_r[g] & (w2_addr_r == s1_addr);
      assign rd_data[g*`LANE_W +: `LANE_W] = lane_q_r[`LANE_W-1:0];
      assign rd_par[g] = lane_q_r[`LANE_W];

      // capture bus into the array on the data edge, byte gated
      always @(posedge core_clk)
      begin
        if (wr_fire && !w2_bw_n_r[g])
        begin
          mem[w2_addr_r] <= {parity_bus_in[g], dq_in[g*`LANE_W +: `LANE_W]};
        end
      end

      // output register; a same-edge write is forwarded so a read
      // right behind a write never returns the stale word
      always @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          lane_q_r <= {(`LANE_W+1){1'b0}};
        end
        else if (rd_fire && hit)
        begin
          lane_q_r <= {parity_bus_in[g], dq_in[g*`LANE_W +: `LANE_W]};
        end
        else if (rd_fire)
        begin
          lane_q_r <= mem[s1_addr];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // drive only for a live read with enable low; the write data phase,
  // the emerging cycle, deselect and sleep all force release
  wire drive;

  assign drive = rd_valid_r & ~oe_sync_r & ~w2_valid_r & ~emerge_r & ~asleep_r;
  assign dq_oe = drive;
  assign parity_bus_oe = drive;
  assign dq_out = rd_data;
  assign parity_bus_out = rd_par;

endmodule

//--- sram_ctrl_model.sv
// controller side of the shared data and parity bus
// assumes the bench sets drive and wdata just after a clock edge
`timescale 1ns/1ns
module sram_ctrl_model
(
  input logic core_clk,
  input logic drive,
  input logic [17:0] wdata,
  input logic [17:0] rdata,
  input logic rdrive,
  output logic [17:0] bus_in
);
  logic [17:0] last_r = 18'h00000;
  // released lines drift: inverse of last level, toggling each edge, so stale data cannot match on the first edge after release
  always @(posedge core_clk)
    last_r <= bus_in;
  always @*
    bus_in = drive ? wdata : (rdrive ? rdata : ~last_r);
endmodule

//--- sram_pin_core_monitor.sv
// port checker for the sram pin core
// bound in from the bench; one clock domain
`timescale 1ns/1ns
module sram_pin_core_monitor
(
  input wire core_clk,
  input wire resetn,
  input wire chip_sel_a_n,
  input wire chip_sel_b,
  input wire chip_sel_c_n,
  input wire write_n,
  input wire advance_or_load,
  input wire clock_qualify_n,
  input wire out_en_n,
  input wire sleep_req,
  input wire [15:0] dq_out,
  input wire dq_oe,
  input wire parity_bus_oe,
  input wire sleep_active
);
  // ----------------------------------------
  // load decode and sequences
  // ----------------------------------------
  wire awake = !sleep_req && !sleep_active;
  wire sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n && awake;
  wire ld = !clock_qualify_n && !advance_or_load;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence desel_ld; ld && !sel; endsequence
  sequence wr_ld; ld && sel && !write_n; endsequence
  sequence rd_ld; ld && sel && write_n && !out_en_n && !$past(out_en_n) && !$past(out_en_n, 2); endsequence
  sequence go; !clock_qualify_n && !out_en_n && awake; endsequence
  a_oe_pair: assert property (dq_oe == parity_bus_oe) else $error("oe pair");
  a_oe_off: assert property (out_en_n [*4] |-> !dq_oe) else $error("oe off");
  a_sleep_quiet: assert property (sleep_active |-> !dq_oe) else $error("sleep drive");
  a_stall_hold: assert property (clock_qualify_n && awake && $stable(out_en_n) |=>
    $stable(dq_out) && $stable(dq_oe)) else $error("stall");
  a_desel_release: assert property (desel_ld ##1 go |=> !dq_oe) else $error("desel");
  a_write_tristate: assert property (wr_ld ##1 go |=> !dq_oe) else $error("write drive");
  a_read_drive: assert property (rd_ld ##1 go |=> dq_oe) else $error("read idle");
  a_sleep_in: assert property (sleep_req [*7] |-> sleep_active) else $error("no sleep");
  a_sleep_out: assert property (!sleep_req [*7] |-> !sleep_active) else $error("stuck sleep");
endmodule

//--- sram_pin_core_test.sv
// self-checking bench for the sram pin core
// assumes the design reads only whole aligned blocks it has written
`timescale 1ns/1ns
module sram_pin_core_test;
  logic core_clk = 0, resetn = 0, write_n = 1, adv = 0, qual_n = 0, oe_n = 0;
  logic sleep = 0, mode = 1, drv = 0, asleep = 0, lin = 0;
  logic [2:0] cs = 3'b101;
  logic [1:0] bw = 2'h3;
  logic [17:0] addr_v = 18'h00000, wdat = 18'h00000;
  logic [17:0] mem [logic [17:0]];
  logic [17:0] exp_q [$];
  integer n_mismatch = 0, checks_done = 0, cycles = 0, seed = 32'hbf1449aa;
  wire [15:0] dq_out;
  wire [1:0] par_out;
  wire [17:0] bus_in;
  wire dq_oe, par_oe, sleep_active;
  always #2 core_clk = ~core_clk;
  sram_pin_core u_dut (.core_clk(core_clk), .resetn(resetn), .addr(addr_v), .chip_sel_a_n(cs[2]),
    .chip_sel_b(cs[1]), .chip_sel_c_n(cs[0]), .write_n(write_n), .advance_or_load(adv),
    .byte_write_sel_n(bw), .clock_qualify_n(qual_n), .out_en_n(oe_n), .sleep_req(sleep),
    .burst_mode_pin(mode), .dq_in(bus_in[15:0]), .dq_out(dq_out), .dq_oe(dq_oe),
    .parity_bus_in(bus_in[17:16]), .parity_bus_out(par_out), .parity_bus_oe(par_oe),
    .sleep_active(sleep_active));
  sram_ctrl_model u_ctrl (.core_clk(core_clk), .drive(drv), .wdata(wdat),
    .rdata({par_out, dq_out}), .rdrive(dq_oe), .bus_in(bus_in));
  task chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    if (exp_q.size() != 0)
    begin
      n_mismatch += exp_q.size();
      $display("BAD pending reads expected 0 seen %0d", exp_q.size());
    end
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task cyc;
    @(posedge core_clk);
    #1;
  endtask
  // one load edge, then a deselected idle so outputs release
  task load(input [2:0] c, input w, input [17:0] a, input [1:0] b);
    cs = c; write_n = w; adv = 0; addr_v = a; bw = b;
    cyc;
    cs = 3'b101; write_n = 1;
  endtask
  task wr(input [2:0] c, input [17:0] a, input [17:0] d, input [1:0] b);
    logic [17:0] m;
    m = mem[a];
    load(c, 0, a, b);
    cyc;
    drv = 1; wdat = d;
    cyc;
    drv = 0;
    if (!b[0]) m = {m[17], d[16], m[15:8], d[7:0]};
    if (!b[1]) m = {d[17], m[16], d[15:8], m[7:0]};
    if (c == 3'b010 && !asleep) mem[a] = m;
  endtask
  // stall holds the qualifier high; the result must stand meanwhile
  task rd(input [2:0] c, input [17:0] a, input integer stall);
    load(c, 1, a, 2'h3);
    if (c == 3'b010 && !asleep && !oe_n) exp_q.push_back(mem[a]);
    cyc;
    if (stall != 0)
    begin
      qual_n = 1;
      repeat (stall) cyc;
      qual_n = 0;
    end
    cyc;
  endtask
  // burst write: word k sits on the bus two edges after its advance
  task bwr(input [17:0] a);
    integer i;
    logic [17:0] d;
    load(3'b010, 0, a, 2'h0);
    adv = 1;
    cyc;
    drv = 1;
    for (i = 0; i < 4; i++)
    begin
      d = 18'($random(seed));
      wdat = d;
      mem[{a[17:2], lin ? a[1:0] + i[1:0] : a[1:0] ^ i[1:0]}] = d;
      if (i == 2) adv = 0;
      cyc;
    end
    drv = 0;
  endtask
  // write then read of the same word on the very next edge
  task wr_rd(input [17:0] a, input [17:0] d);
    cs = 3'b010; write_n = 0; adv = 0; addr_v = a; bw = 2'h0;
    cyc;
    write_n = 1;
    mem[a] = d;
    exp_q.push_back(d);
    cyc;
    cs = 3'b101; drv = 1; wdat = d;
    cyc;
    drv = 0;
    cyc;
  endtask
  task burst(input [17:0] a);
    integer i;
    load(3'b010, 1, a, 2'h3);
    for (i = 0; i < 4; i++)
    begin
      adv = i < 3;
      exp_q.push_back(mem[{a[17:2], lin ? a[1:0] + i[1:0] : a[1:0] ^ i[1:0]}]);
      cyc;
    end
    adv = 0;
    cyc;
  endtask
  task rst;
    resetn = 0;
    repeat (2) cyc;
    resetn = 1;
    repeat (2) cyc;
  endtask
  // results appear whenever the device drives on a qualified edge
  always @(posedge core_clk)
    if (resetn && !qual_n && (dq_oe === 1'b1 || par_oe === 1'b1))
      if (exp_q.size() == 0) chk("stray drive", {16'h0, par_oe, dq_oe}, 18'h0);
      else
      begin
        chk("oe pair", {16'h0, par_oe, dq_oe}, 18'h3);
        chk("read data", {par_out, dq_out}, exp_q.pop_front());
      end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      $display("BAD cycle limit expected below 3000 seen %0d", cycles);
      results;
    end
  end
  initial
  begin : main
    integer i;
    logic [17:0] a;
    rst;
    a = 18'($random(seed));
    for (i = 0; i < 4; i++) wr(3'b010, {a[17:2], i[1:0]}, 18'($random(seed)), 2'h0);
    burst(a);
    bwr(a);
    burst(a);
    for (i = 0; i < 4; i++) wr(3'b010, {a[17:2], i[1:0]}, 18'($random(seed)), i[1:0]);
    for (i = 0; i < 4; i++) rd(3'b010, {a[17:2], i[1:0]}, i);
    wr_rd(a, 18'($random(seed)));
    for (i = 0; i < 8; i++)
      if (i != 2)
      begin
        wr(i[2:0], a, 18'($random(seed)), 2'h0);
        rd(i[2:0], a, 0);
      end
    oe_n = 1;
    repeat (4) cyc;
    rd(3'b010, a, 0);
    wr(3'b010, a, 18'($random(seed)), 2'h0);
    oe_n = 0;
    repeat (4) cyc;
    rd(3'b010, a, 0);
    sleep = 1;
    repeat (8) cyc;
    asleep = 1;
    chk("sleep", {17'h0, sleep_active}, 18'h1);
    wr(3'b010, a, 18'($random(seed)), 2'h0);
    rd(3'b010, a, 0);
    sleep = 0;
    repeat (8) cyc;
    asleep = 0;
    chk("wake", {17'h0, sleep_active}, 18'h0);
    rd(3'b010, a, 0);
    mode = 0;
    lin = 1;
    repeat (4) cyc;
    rst;
    burst(a);
    bwr(a);
    burst(a);
    repeat (4) cyc;
    results;
  end
endmodule
bind sram_pin_core sram_pin_core_monitor u_mon (.core_clk(core_clk), .resetn(resetn), .chip_sel_a_n(chip_sel_a_n),
  .chip_sel_b(chip_sel_b), .chip_sel_c_n(chip_sel_c_n), .write_n(write_n), .advance_or_load(advance_or_load),
  .clock_qualify_n(clock_qualify_n), .out_en_n(out_en_n), .sleep_req(sleep_req), .dq_out(dq_out), .dq_oe(dq_oe),
  .parity_bus_oe(parity_bus_oe), .sleep_active(sleep_active));
